// ===== uep_pkg.sv
// uep_pkg: register map, field positions and token/handshake codes
// for the endpoint 0 control and pull-up test block.
// assumes: 16-bit registers in the low half of a 32-bit wishbone word.
package uep_pkg;
	// register word indices (the offsets are not all multiples of four,
	// so each offset is kept as an index and the bus address is index * 4)
	localparam logic [31:0] PULLUP_TEST_IDX    = 32'h5000183E;
	localparam logic [31:0] EP0_CTRL_IDX       = 32'h50001840;
	localparam logic [31:0] FUNC_ADDR_IDX      = 32'h00000100;
	localparam logic [31:0] EP0_STATUS_IDX     = 32'h00000101;
	localparam logic [7:0]  WB_ADDR_W          = 8'h20;

	// pull-up test register fields
	localparam int PU_READBACK_BIT = 7;
	localparam int PU_REDUCED_BIT  = 6;
	localparam int PU_POSITIVE_BIT = 5;
	localparam int PU_TEST_EN_BIT  = 4;
	localparam int PU_NEGATIVE_BIT = 2;
	localparam int PU_RSV_A_BIT    = 1;
	localparam int PU_RSV_B_BIT    = 0;
	localparam logic [15:0] PU_WRITE_MASK = 16'h0077;

	// endpoint 0 control fields
	localparam int EP0_STALL_BIT   = 7;
	localparam int EP0_DEFAULT_BIT = 6;
	localparam logic [3:0] EP0_NUMBER = 4'h0;

	// function address register: enable in bit 7, address in 6:0
	localparam int FA_ENABLE_BIT = 7;

	// status register fields (own layout)
	localparam int ST_RX_LAST_BIT = 0;
	localparam int ST_TX_DONE_BIT = 1;

	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [6:0]  DEFAULT_ADDR = 7'h00;

	typedef enum logic [1:0] {
		UEP_TOK_OUT,
		UEP_TOK_IN,
		UEP_TOK_SETUP,
		UEP_TOK_NONE
	} uep_token_t;

	typedef enum logic [1:0] {
		UEP_HS_NONE,
		UEP_HS_STALL,
		UEP_HS_DATA
	} uep_resp_t;
endpackage : uep_pkg

// ===== uep_link_if.sv
// uep_link_if: token/response path between the core and the stall unit.
// assumes: one clock, all signals on i_clock.
`timescale 1ns/1ps
`default_nettype none
interface uep_link_if;
	logic              tok_valid;
	uep_pkg::uep_token_t tok;
	logic              tx_en;
	logic              rx_en;
	logic              stall_set;
	uep_pkg::uep_resp_t resp;
	modport core (output tok_valid, output tok, output tx_en, output rx_en,
		output stall_set, input resp);
	modport unit (input tok_valid, input tok, input tx_en, input rx_en,
		input stall_set, output resp);
endinterface : uep_link_if
`default_nettype wire

// ===== uep_stall.sv
// uep_stall: decides the handshake for one token on endpoint 0.
// assumes: token decode and addressing are done upstream.
`timescale 1ns/1ps
`default_nettype none
module uep_stall (
	uep_link_if.unit link
);
	wire stall_in;
	wire stall_out;
	// (RL6) stall in or out
	assign stall_in  = link.tok == uep_pkg::UEP_TOK_IN && link.tx_en;
	assign stall_out = link.tok == uep_pkg::UEP_TOK_OUT && link.rx_en;
	// (RL7) setup never stalled
	assign link.resp = !link.tok_valid ? uep_pkg::UEP_HS_NONE :
		(link.stall_set && (stall_in || stall_out)) ? uep_pkg::UEP_HS_STALL :
		uep_pkg::UEP_HS_DATA;
endmodule : uep_stall
`default_nettype wire

// ===== uep_pullup.sv
// uep_pullup: maps the pull-up test register onto the three switches.
// assumes: switch outputs are high for closed, driven every cycle.
`timescale 1ns/1ps
`default_nettype none
module uep_pullup (
	input  wire logic [15:0] i_test_reg,
	input  wire logic        i_vbus_ok,
	input  wire logic        i_attach,
	output logic             o_pos_close,
	output logic             o_neg_close,
	output logic             o_red_close
);
	wire test_en;
	wire normal_pos;
	assign test_en    = i_test_reg[uep_pkg::PU_TEST_EN_BIT];
	// full-speed device: normal mode pulls up the positive line only
	assign normal_pos = i_vbus_ok && i_attach;
	// (RL1) test overrides switches
	// (RL3) positive override, low closes
	assign o_pos_close = test_en ? !i_test_reg[uep_pkg::PU_POSITIVE_BIT] : normal_pos;
	// (RL4) negative override, low closes
	assign o_neg_close = test_en ? !i_test_reg[uep_pkg::PU_NEGATIVE_BIT] : 1'b0;
	// (RL2) reduced pull-up override
	assign o_red_close = test_en ? !i_test_reg[uep_pkg::PU_REDUCED_BIT] : 1'b0;
endmodule : uep_pullup
`default_nettype wire

// ===== uep_top.sv
// uep_top: endpoint 0 control and pull-up test registers over wishbone.
// assumes: a usb engine delivers decoded tokens and reports sent packets;
// the host-side transfer sequencing is outside this block.
//
// Behaviour
// (RL1) test enable hands switches to overrides
// (RL2) reduced switch bit: 0 closes, 1 opens
// (RL3) positive pull-up bit: 0 on, 1 off
// (RL4) negative pull-up bit: 0 on, 1 off
// (RL5) software keeps test bits 1:0 zero
// (RL6) stall bit stalls enabled in/out tokens
// (RL7) setup tokens never get a stall
// (RL8) stall sets rx last and tx done
// (RL9) default bit answers address zero
// (RL10) sent in packet clears default bit
// (RL11) address switch only after status phase
// (RL12) software initialises address and control after reset
// (RL13) software sets default bit and new address
// (RL14) endpoint number reads zero, writes ignored
// (RL15) reserved and readback bits read zero
`timescale 1ns/1ps
`default_nettype none
module uep_top (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [31:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// usb engine token side
	input  wire logic        i_tok_valid,
	input  wire logic [1:0]  i_tok_kind,
	input  wire logic [6:0]  i_tok_addr,
	input  wire logic [3:0]  i_tok_ep,
	input  wire logic        i_tx_en,
	input  wire logic        i_rx_en,
	input  wire logic        i_in_sent,
	// usb engine answer side
	output logic             o_addr_match,
	output logic             o_hs_stall,
	output logic             o_hs_data,
	output logic             o_stall_done,
	// pull-up switches
	input  wire logic        i_vbus_ok,
	output logic             o_pos_pullup,
	output logic             o_neg_pullup,
	output logic             o_red_pullup
);
	logic [15:0] test_ff;
	logic [7:0]  ep0_ff;
	logic [7:0]  faddr_ff;
	logic [6:0]  act_addr_ff;
	logic        rx_last_ff;
	logic        tx_done_ff;
	logic        stall_done_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [15:0] nxt_test;
	logic [7:0]  nxt_ep0;
	logic [31:0] nxt_rdata;
	// bus power comes from an analog detector, asynchronous to i_clock
	logic        vbus_meta_ff;
	logic        vbus_s2_ff;
	logic        vbus_s3_ff;
	logic        vbus_ok_ff;
	wire         vbus_agree;

	uep_link_if link ();

	// word index = byte address / 4; low bits ignored
	function automatic logic hit(input logic [31:0] adr, input logic [31:0] idx);
		hit = adr[31:2] == idx[29:0];
	endfunction : hit

	wire req;
	wire wr;
	wire rd_status;
	wire sel_test;
	wire sel_ep0;
	wire sel_fa;
	wire sel_st;
	wire [15:0] wdat;
	wire [15:0] lane_mask;
	wire        stalled;
	wire        dflt;
	wire [6:0]  match_addr;

	assign req  = i_wb_cyc && i_wb_stb && !ack_ff;
	assign wr   = req && i_wb_we;
	assign sel_test = hit(i_wb_adr, uep_pkg::PULLUP_TEST_IDX);
	assign sel_ep0  = hit(i_wb_adr, uep_pkg::EP0_CTRL_IDX);
	assign sel_fa   = hit(i_wb_adr, uep_pkg::FUNC_ADDR_IDX);
	assign sel_st   = hit(i_wb_adr, uep_pkg::EP0_STATUS_IDX);
	assign rd_status = req && !i_wb_we && sel_st;
	assign wdat = i_wb_dat[15:0];
	assign lane_mask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	// (RL15) writable fields only
	// (RL5) low test bits held zero
	assign nxt_test = (wr && sel_test)
		? ((test_ff & ~(lane_mask & uep_pkg::PU_WRITE_MASK))
			| (wdat & lane_mask & uep_pkg::PU_WRITE_MASK)
			& ~16'h0003)
		: test_ff;

	// (RL14) endpoint field not stored
	// (RL10) sent in clears default
	always_comb begin
		nxt_ep0 = ep0_ff;
		if (wr && sel_ep0 && i_wb_sel[0]) begin
			nxt_ep0 = {wdat[7:6], 6'h00};
		end
		if (i_in_sent) begin
			nxt_ep0[uep_pkg::EP0_DEFAULT_BIT] = 1'b0;
		end
	end

	assign link.tok_valid = i_tok_valid && o_addr_match;
	assign link.tok       = uep_pkg::uep_token_t'(i_tok_kind);
	assign link.tx_en     = i_tx_en;
	assign link.rx_en     = i_rx_en;
	assign link.stall_set = ep0_ff[uep_pkg::EP0_STALL_BIT];

	uep_stall u_stall (
		.link (link)
	);

	assign stalled = link.resp == uep_pkg::UEP_HS_STALL;
	assign dflt    = ep0_ff[uep_pkg::EP0_DEFAULT_BIT];
	// (RL9) default address selection
	assign match_addr = dflt ? uep_pkg::DEFAULT_ADDR : act_addr_ff;
	assign o_addr_match = (dflt || faddr_ff[uep_pkg::FA_ENABLE_BIT])
		&& i_tok_addr == match_addr && i_tok_ep == uep_pkg::EP0_NUMBER;
	assign o_hs_stall = stalled;
	assign o_hs_data  = link.resp == uep_pkg::UEP_HS_DATA;
	assign o_stall_done = stall_done_ff;

	always_comb begin
		nxt_rdata = 32'h00000000;
		if (sel_test) begin
			// (RL15) readback bit zero
			nxt_rdata[15:0] = test_ff;
		end else if (sel_ep0) begin
			// (RL14) endpoint reads zero
			nxt_rdata[7:0] = {ep0_ff[7:6], 2'b00, uep_pkg::EP0_NUMBER};
		end else if (sel_fa) begin
			nxt_rdata[7:0] = faddr_ff;
		end else if (sel_st) begin
			nxt_rdata[uep_pkg::ST_RX_LAST_BIT] = rx_last_ff;
			nxt_rdata[uep_pkg::ST_TX_DONE_BIT] = tx_done_ff;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			test_ff  <= uep_pkg::REG_RESET;
			ep0_ff   <= 8'h00;
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else begin
			test_ff  <= nxt_test;
			ep0_ff   <= nxt_ep0;
			// unmapped addresses ack with zero data
			ack_ff   <= req;
			rdata_ff <= req ? nxt_rdata : 32'h00000000;
		end
	end

	// function address; the active address follows only once default drops
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			faddr_ff    <= 8'h00;
			act_addr_ff <= 7'h00;
		end else begin
			if (wr && sel_fa && i_wb_sel[0]) begin
				faddr_ff <= wdat[7:0];
			end
			// (RL11) switch after status phase
			// next value used so no cycle answers the stale address
			if (!nxt_ep0[uep_pkg::EP0_DEFAULT_BIT]) begin
				act_addr_ff <= faddr_ff[6:0];
			end
		end
	end

	// (RL8) stall sets status flags
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rx_last_ff    <= 1'b0;
			tx_done_ff    <= 1'b0;
			stall_done_ff <= 1'b0;
		end else begin
			stall_done_ff <= stalled;
			// set beats the read-clear
			rx_last_ff <= stall_done_ff || (rx_last_ff && !rd_status);
			tx_done_ff <= stall_done_ff || i_in_sent || (tx_done_ff && !rd_status);
		end
	end

	// a change counts once stages two and three agree
	assign vbus_agree = vbus_s2_ff == vbus_s3_ff;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			vbus_meta_ff <= 1'b0;
			vbus_s2_ff   <= 1'b0;
			vbus_s3_ff   <= 1'b0;
			vbus_ok_ff   <= 1'b0;
		end else begin
			vbus_meta_ff <= i_vbus_ok;
			vbus_s2_ff   <= vbus_meta_ff;
			vbus_s3_ff   <= vbus_s2_ff;
			if (vbus_agree) begin
				vbus_ok_ff <= vbus_s2_ff;
			end
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdata_ff;

	uep_pullup u_pullup (
		.i_test_reg  (test_ff),
		.i_vbus_ok   (vbus_ok_ff),
		.i_attach    (1'b1),
		.o_pos_close (o_pos_pullup),
		.o_neg_close (o_neg_pullup),
		.o_red_close (o_red_pullup)
	);
endmodule : uep_top
`default_nettype wire

// ===== uep_top_assertions.sv
// uep_chk: port properties of uep_top
// assumes: register writes carry byte lane 0
`timescale 1ns/1ps
`default_nettype none
module uep_chk (
	input wire logic        i_clock, i_srst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
	input wire logic [31:0] i_wb_adr, i_wb_dat, o_wb_dat,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [1:0]  i_tok_kind,
	input wire logic        i_tok_valid, i_tx_en, i_rx_en, i_vbus_ok, o_addr_match, o_hs_data,
	input wire logic        o_hs_stall, o_stall_done, o_pos_pullup, o_neg_pullup, o_red_pullup
);
	logic [15:0] pu_ff;
	logic        stall_ff;
	logic [2:0]  vbus_age_ff;
	logic        vbus_prev_ff;
	wire logic   wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
	wire logic   st = i_tok_valid & o_addr_match & stall_ff
		& (i_tok_kind == 2'h1 ? i_tx_en : i_tok_kind == 2'h0 & i_rx_en);
	// shadow of written bits, stored on the edge the design stores them
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pu_ff    <= 16'h0000;
			stall_ff <= 1'b0;
		end else if (wr && i_wb_adr == uep_pkg::PULLUP_TEST_IDX << 2) begin
			pu_ff <= i_wb_dat[15:0];
		end else if (wr && i_wb_adr == uep_pkg::EP0_CTRL_IDX << 2) begin
			stall_ff <= i_wb_dat[7];
		end
	end
	// cycles bus power has been steady; the design synchronises it first
	always_ff @(posedge i_clock) begin
		vbus_prev_ff <= i_vbus_ok;
		if (i_srst || i_vbus_ok != vbus_prev_ff) begin
			vbus_age_ff <= 3'h0;
		end else if (vbus_age_ff != 3'h7) begin
			vbus_age_ff <= vbus_age_ff + 3'h1;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	a_ack_answer: assert property (wr |=> o_wb_ack) else $error("ack missing");
	a_rdat_upper: assert property (o_wb_dat[31:16] == 16'h0000) else $error("upper bits");
	a_pos_switch: assert property (pu_ff[4] |-> o_pos_pullup == !pu_ff[5])
		else $error("positive switch");
	a_pos_normal: assert property (!pu_ff[4] && vbus_age_ff >= 3'h5
		|-> o_pos_pullup == i_vbus_ok) else $error("positive switch normal mode");
	a_neg_switch: assert property (o_neg_pullup == (pu_ff[4] & !pu_ff[2]))
		else $error("negative switch");
	a_red_switch: assert property (o_red_pullup == (pu_ff[4] & !pu_ff[6]))
		else $error("reduced switch");
	a_stall_set: assert property (st |-> o_hs_stall) else $error("stall missing");
	a_stall_only: assert property (o_hs_stall |-> st) else $error("stray stall");
	a_data_answer: assert property (o_hs_data == (i_tok_valid && o_addr_match && !o_hs_stall))
		else $error("data answer");
	a_setup_quiet: assert property (i_tok_valid && i_tok_kind == 2'h2 |-> !o_hs_stall)
		else $error("setup stalled");
	a_stall_done: assert property (o_stall_done == $past(o_hs_stall))
		else $error("stall done");
endmodule : uep_chk
bind uep_top uep_chk u_chk (
	.i_clock (i_clock), .i_srst (i_srst), .i_wb_cyc (i_wb_cyc), .i_wb_stb (i_wb_stb),
	.i_wb_we (i_wb_we), .o_wb_ack (o_wb_ack), .i_wb_adr (i_wb_adr), .i_wb_dat (i_wb_dat),
	.o_wb_dat (o_wb_dat), .i_wb_sel (i_wb_sel), .i_tok_kind (i_tok_kind),
	.i_tok_valid (i_tok_valid), .i_tx_en (i_tx_en), .i_rx_en (i_rx_en),
	.i_vbus_ok (i_vbus_ok), .o_addr_match (o_addr_match), .o_hs_data (o_hs_data),
	.o_hs_stall (o_hs_stall), .o_stall_done (o_stall_done), .o_pos_pullup (o_pos_pullup),
	.o_neg_pullup (o_neg_pullup), .o_red_pullup (o_red_pullup));
`default_nettype wire

// ===== uep_host_model.sv
// uep_host_model: host issuing tokens to endpoint 0
// assumes: tasks are called after a rising edge
`timescale 1ns/1ps
`default_nettype none
module uep_host_model (
	input  wire logic       i_clock,
	output logic            o_valid,
	output logic      [1:0] o_kind,
	output logic      [6:0] o_addr,
	output logic            o_tx_en,
	output logic            o_rx_en,
	output logic            o_in_sent
);
	initial begin
		{o_valid, o_kind, o_addr, o_tx_en, o_rx_en, o_in_sent} = 13'h0CAA;
	end
	task automatic send(input logic [1:0] k, input logic [6:0] a, input logic t, input logic r);
		@(posedge i_clock);
		{o_valid, o_kind, o_addr, o_tx_en, o_rx_en} <= {1'b1, k, a, t, r};
		#1;
	endtask : send
	// released lines change pattern so no stale address lingers
	task automatic idle();
		@(posedge i_clock);
		{o_valid, o_kind, o_addr} <= {3'h3, ~o_addr};
	endtask : idle
	task automatic sent();
		@(posedge i_clock);
		o_in_sent <= 1'b1;
		@(posedge i_clock);
		o_in_sent <= 1'b0;
	endtask : sent
endmodule : uep_host_model
`default_nettype wire

// ===== uep_tb.sv
// tb: register, pull-up, stall and address scenarios
// assumes: host model drives tokens, bench drives wishbone
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [31:0] PU = uep_pkg::PULLUP_TEST_IDX;
	localparam logic [31:0] EC = uep_pkg::EP0_CTRL_IDX;
	localparam logic [31:0] FA = uep_pkg::FUNC_ADDR_IDX;
	localparam logic [31:0] SR = uep_pkg::EP0_STATUS_IDX;
	logic        i_clock, i_srst, i_wb_cyc, i_wb_stb, i_wb_we, i_vbus_ok, o_wb_ack;
	logic [31:0] i_wb_adr, i_wb_dat, o_wb_dat, q;
	logic [3:0]  i_wb_sel, i_tok_ep;
	logic [1:0]  i_tok_kind;
	logic [6:0]  i_tok_addr;
	logic        i_tok_valid, i_tx_en, i_rx_en, i_in_sent, o_addr_match, o_hs_stall;
	logic        o_hs_data, o_stall_done, o_pos_pullup, o_neg_pullup, o_red_pullup;
	int          miscompares = 0;
	int          check_count = 0;
	uep_top dut (
		.i_clock (i_clock), .i_srst (i_srst), .i_wb_cyc (i_wb_cyc), .i_wb_stb (i_wb_stb),
		.i_wb_we (i_wb_we), .i_wb_adr (i_wb_adr), .i_wb_sel (i_wb_sel), .i_wb_dat (i_wb_dat),
		.o_wb_dat (o_wb_dat), .o_wb_ack (o_wb_ack), .i_tok_valid (i_tok_valid),
		.i_tok_kind (i_tok_kind), .i_tok_addr (i_tok_addr), .i_tok_ep (i_tok_ep),
		.i_tx_en (i_tx_en), .i_rx_en (i_rx_en), .i_in_sent (i_in_sent),
		.o_addr_match (o_addr_match), .o_hs_stall (o_hs_stall), .o_hs_data (o_hs_data),
		.o_stall_done (o_stall_done), .i_vbus_ok (i_vbus_ok), .o_pos_pullup (o_pos_pullup),
		.o_neg_pullup (o_neg_pullup), .o_red_pullup (o_red_pullup));
	uep_host_model host (.i_clock(i_clock), .o_valid(i_tok_valid), .o_kind(i_tok_kind),
		.o_addr(i_tok_addr), .o_tx_en(i_tx_en), .o_rx_en(i_rx_en), .o_in_sent(i_in_sent));
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [31:0] idx, input logic [15:0] d);
		@(posedge i_clock);
		{i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
		i_wb_adr <= idx << 2;
		i_wb_dat <= {16'h0000, d};
		do @(posedge i_clock); while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		{i_wb_cyc, i_wb_stb} <= 2'b00;
		@(posedge i_clock);
	endtask : wb
	task automatic rd(input logic [31:0] idx, input logic [15:0] e);
		wb(1'b0, idx, 16'h0000);
		chk({16'h0000, e}, q);
	endtask : rd
	task automatic tok(input logic [1:0] k, input logic [6:0] a, input logic t, input logic r,
		input logic m, input logic s);
		host.send(k, a, t, r);
		chk({31'h0, m}, {31'h0, o_addr_match});
		chk({31'h0, s}, {31'h0, o_hs_stall});
		chk({31'h0, m & ~s}, {31'h0, o_hs_data});
		host.idle();
		#1 chk({31'h0, s}, {31'h0, o_stall_done});
	endtask : tok
	task automatic t_regs();
		rd(PU, 16'h0000);
		rd(EC, 16'h0000);
		chk(32'h4, {29'h0, o_pos_pullup, o_neg_pullup, o_red_pullup});
		wb(1'b1, PU, 16'hFFFC);
		rd(PU, 16'h0074);
		wb(1'b1, EC, 16'hFFFF);
		rd(EC, 16'h00C0);
		rd(32'h00000200, 16'h0000);
	endtask : t_regs
	task automatic t_pullup();
		logic [2:0] i;
		for (int n = 0; n < 8; n++) begin
			i = n[2:0];
			i_vbus_ok <= i[0] ^ i[1];
			wb(1'b1, PU, {9'h000, i[2], i[1], 2'b10, i[0], 2'b00});
			chk({29'h0, ~i[1], ~i[0], ~i[2]}, {29'h0, o_pos_pullup, o_neg_pullup, o_red_pullup});
		end
		i_vbus_ok <= 1'b0;
		wb(1'b1, PU, 16'h0064);
		chk(32'h0, {29'h0, o_pos_pullup, o_neg_pullup, o_red_pullup});
	endtask : t_pullup
	task automatic t_stall();
		wb(1'b1, FA, 16'h0080);
		wb(1'b1, EC, 16'h0000);
		wb(1'b1, EC, 16'h0080);
		tok(2'h1, 7'h00, 1'b1, 1'b0, 1'b1, 1'b1);
		tok(2'h0, 7'h00, 1'b0, 1'b1, 1'b1, 1'b1);
		tok(2'h2, 7'h00, 1'b1, 1'b1, 1'b1, 1'b0);
		tok(2'h1, 7'h00, 1'b0, 1'b1, 1'b1, 1'b0);
		rd(SR, 16'h0003);
		rd(SR, 16'h0000);
		wb(1'b1, EC, 16'h0000);
		tok(2'h1, 7'h00, 1'b1, 1'b0, 1'b1, 1'b0);
	endtask : t_stall
	task automatic t_addr();
		wb(1'b1, EC, 16'h0040);
		wb(1'b1, FA, 16'h0085);
		tok(2'h2, 7'h00, 1'b0, 1'b0, 1'b1, 1'b0);
		tok(2'h2, 7'h05, 1'b0, 1'b0, 1'b0, 1'b0);
		host.sent();
		rd(EC, 16'h0000);
		tok(2'h2, 7'h05, 1'b0, 1'b0, 1'b1, 1'b0);
		tok(2'h2, 7'h00, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask : t_addr
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	initial begin
		{i_srst, i_wb_cyc, i_wb_stb, i_wb_we, i_vbus_ok} = 5'h11;
		{i_wb_adr, i_wb_dat, i_wb_sel, i_tok_ep} = {64'h0, 4'hF, 4'h0};
		repeat (16) @(posedge i_clock);
		i_srst <= 1'b0;
		t_regs();
		t_pullup();
		t_stall();
		t_addr();
		tally_and_finish();
	end
	initial begin
		repeat (3000) @(posedge i_clock);
		miscompares++;
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
